// [hdl/eq_mix_defs.svh]
// register offsets, field positions and reset values of the shaping and output mix registers
//
// How it works
// - band gains 5 bits, reset 01100 is 0dB
// - band 3 centre at 6:5, reset 01
// - band 4 centre at 6:5, reset 01
// - band 5 cutoff at 6:5, no width bit
// - bands 2-4 width bit 8, reset narrow
// - path select changes only with converters off
// - stereo depth bits 3:0 at 0x29, reset 0
// - cross-channel playback selects at bits 5, 6
// - left mixer: play 1, bypass 0, aux 0
// - right mixer: play select 1, aux 0
// - bypass and aux levels 3 bits, reset 000
// - mixer enables at power bits 2, 3
// - phones level 6 bits, reset 111001
// - phones levels wait for unstored commit bit 8
// - zero-cross enable delays gain change to crossing
// - phones mute at bit 6, reset 0
// - speaker level same encoding as phones
// - speaker mute bit 6, zero-cross bit 7
// - path select bit 8 resets to playback
`ifndef EQ_MIX_DEFS_SVH
`define EQ_MIX_DEFS_SVH

// bus geometry
`define ADDR_W 10
`define IDX_W 8
`define DATA_W 32
`define REG_W 9

// register indices, byte address is four times the index
`define IDX_POWER 8'h03
`define IDX_PATH 8'h12
`define IDX_BAND2 8'h13
`define IDX_BAND3 8'h14
`define IDX_BAND4 8'h15
`define IDX_BAND5 8'h16
`define IDX_DEPTH 8'h29
`define IDX_XMIX 8'h31
`define IDX_LMIX 8'h32
`define IDX_RMIX 8'h33
`define IDX_HP_L 8'h34
`define IDX_HP_R 8'h35
`define IDX_SPK_L 8'h36
`define IDX_REC_EN 8'h40
`define IDX_STATUS 8'h41

// field positions
`define B_PLAY_L 0
`define B_PLAY_R 1
`define B_MIX_L_ON 2
`define B_MIX_R_ON 3
`define B_REC_L 0
`define B_REC_R 1
`define B_PATH 8
`define B_WIDTH 8
`define F_GAIN 4:0
`define F_FREQ 6:5
`define F_DEPTH 3:0
`define B_R2L 5
`define B_L2R 6
`define B_SAME 0
`define B_BYP 1
`define F_BYP_LVL 4:2
`define B_AUX 5
`define F_AUX_LVL 8:6
`define F_LEVEL 5:0
`define B_SILENCE 6
`define B_ZC 7
`define B_COMMIT 8
`define B_ST_HP_L 0
`define B_ST_HP_R 1
`define B_ST_SPK 2

// reset values
`define RST_GAIN 5'h0C
`define RST_FREQ 2'h1
`define RST_DEPTH 4'h0
`define RST_MIX_LVL 3'h0
`define RST_LEVEL 6'h39
`define RST_PATH 1'b1
`define RST_SAME 1'b1

`endif

// [hdl/eq_mix_pkg.sv]
// types shared by the shaping and output mix register bank
package eq_mix_pkg;

  // settings driven out to the signal path, all held in flip-flops
  typedef struct packed {
    logic left_record_conv_en;
    logic right_record_conv_en;
    logic left_playback_conv_en;
    logic right_playback_conv_en;
    logic left_mixer_on;
    logic right_mixer_on;
    logic shaping_path_sel;
    logic band2_width_sel;
    logic [4:0] band3_gain;
    logic [1:0] band3_centre_sel;
    logic band3_width_sel;
    logic [4:0] band4_gain;
    logic [1:0] band4_centre_sel;
    logic band4_width_sel;
    logic [4:0] band5_gain;
    logic [1:0] band5_cutoff_sel;
    logic [3:0] stereo_depth;
    logic right_play_to_left_mix;
    logic left_play_to_right_mix;
    logic left_play_to_left_mix;
    logic left_bypass_to_mix;
    logic [2:0] left_bypass_level;
    logic left_aux_to_mix;
    logic [2:0] left_aux_level;
    logic right_play_to_right_mix;
    logic [2:0] right_bypass_level;
    logic right_aux_to_mix;
    logic [2:0] right_aux_level;
    logic left_phones_silence;
    logic right_phones_silence;
    logic left_phones_zero_cross;
    logic right_phones_zero_cross;
    logic left_speaker_silence;
    logic left_speaker_zero_cross;
  } cfg_s;

  // gains that the output amplifiers actually use
  typedef struct packed {
    logic [5:0] left_phones_level;
    logic [5:0] right_phones_level;
    logic [5:0] left_speaker_level;
  } level_s;

endpackage

// [hdl/gain_apply.sv]
// one output gain: takes a new target and applies it now or at a zero crossing
`include "eq_mix_defs.svh"

module gain_apply #(
  parameter int WIDTH = 6,
  parameter logic [WIDTH-1:0] RESET_LEVEL = '0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // new target
  input wire logic load,
  input wire logic [WIDTH-1:0] target,
  // zero-cross control
  input wire logic zc_en,
  input wire logic zc_event,
  // applied gain
  output logic [WIDTH-1:0] level_q,
  output logic pending_q
);

  logic [WIDTH-1:0] level_d;
  logic [WIDTH-1:0] target_q;
  logic [WIDTH-1:0] target_d;
  logic pending_d;

  // next gain: a fresh load with zero-cross off goes straight through
  always_comb begin
    level_d = level_q;
    target_d = target_q;
    pending_d = pending_q;
    if (load) begin
      target_d = target;
      if (zc_en) begin
        pending_d = 1'b1;
      end else begin
        level_d = target;
        pending_d = 1'b0;
      end
    end else if (pending_q && (zc_event || !zc_en)) begin
      level_d = target_q;
      pending_d = 1'b0;
    end
  end

  // gain registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= RESET_LEVEL;
      target_q <= RESET_LEVEL;
      pending_q <= 1'b0;
    end else begin
      level_q <= level_d;
      target_q <= target_d;
      pending_q <= pending_d;
    end
  end

endmodule

// [hdl/eq_3d_output_mix_ctrl_regs.sv]
// apb register bank for equaliser, 3d depth and output mixer controls
//
// The APB slave port is this design's own decision.
`include "eq_mix_defs.svh"

module eq_3d_output_mix_ctrl_regs (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [`DATA_W-1:0] pwdata,
  output logic [`DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // zero-crossing detectors of the output signals, asynchronous
  input wire logic hp_left_crossing,
  input wire logic hp_right_crossing,
  input wire logic spk_left_crossing,
  // settings to the signal path
  output eq_mix_pkg::cfg_s cfg,
  output eq_mix_pkg::level_s levels
);

  //////////////////////////////////////////////////////////////////////
  // state

  eq_mix_pkg::cfg_s cfg_q;
  eq_mix_pkg::cfg_s cfg_d;
  logic [5:0] hp_l_stage_q;
  logic [5:0] hp_l_stage_d;
  logic [5:0] hp_r_stage_q;
  logic [5:0] hp_r_stage_d;
  logic [5:0] spk_stage_q;
  logic [5:0] spk_stage_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [`DATA_W-1:0] prdata_q;
  logic [`DATA_W-1:0] prdata_d;
  logic [2:0] zc_meta_q;
  logic [2:0] zc_sync_q;
  logic [2:0] zc_last_q;
  logic [2:0] zc_event;
  logic commit_hp;
  logic load_spk;
  logic hp_l_pending;
  logic hp_r_pending;
  logic spk_pending;
  logic [5:0] hp_l_level;
  logic [5:0] hp_r_level;
  logic [5:0] spk_level;

  //////////////////////////////////////////////////////////////////////
  // bus decode

  logic [`IDX_W-1:0] idx;
  logic aligned;
  logic access_start;
  logic access_end;
  logic wr_en;
  logic [`REG_W-1:0] wd;
  logic converters_idle;

  // index of the addressed word and phase of the transfer
  assign idx = paddr[`ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign access_start = psel && penable && !pready_q;
  assign access_end = psel && penable && pready_q;
  assign wr_en = access_end && pwrite && !pslverr_q;
  assign wd = pwdata[`REG_W-1:0];
  assign converters_idle = !cfg_q.left_record_conv_en && !cfg_q.right_record_conv_en &&
                           !cfg_q.left_playback_conv_en && !cfg_q.right_playback_conv_en;

  //////////////////////////////////////////////////////////////////////
  // register file

  // read mux, write update and the answer of the slave
  always_comb begin
    logic [`REG_W-1:0] rv;
    logic hit;
    rv = '0;
    hit = aligned;
    cfg_d = cfg_q;
    hp_l_stage_d = hp_l_stage_q;
    hp_r_stage_d = hp_r_stage_q;
    spk_stage_d = spk_stage_q;
    commit_hp = 1'b0;
    load_spk = 1'b0;
    if (idx == `IDX_POWER) begin
      rv[`B_PLAY_L] = cfg_q.left_playback_conv_en;
      rv[`B_PLAY_R] = cfg_q.right_playback_conv_en;
      rv[`B_MIX_L_ON] = cfg_q.left_mixer_on;
      rv[`B_MIX_R_ON] = cfg_q.right_mixer_on;
      if (wr_en) begin
        cfg_d.left_playback_conv_en = wd[`B_PLAY_L];
        cfg_d.right_playback_conv_en = wd[`B_PLAY_R];
        cfg_d.left_mixer_on = wd[`B_MIX_L_ON];
        cfg_d.right_mixer_on = wd[`B_MIX_R_ON];
      end
    end else if (idx == `IDX_REC_EN) begin
      rv[`B_REC_L] = cfg_q.left_record_conv_en;
      rv[`B_REC_R] = cfg_q.right_record_conv_en;
      if (wr_en) begin
        cfg_d.left_record_conv_en = wd[`B_REC_L];
        cfg_d.right_record_conv_en = wd[`B_REC_R];
      end
    end else if (idx == `IDX_PATH) begin
      rv[`B_PATH] = cfg_q.shaping_path_sel;
      // the path may only move while every converter is stopped
      if (wr_en && converters_idle) begin
        cfg_d.shaping_path_sel = wd[`B_PATH];
      end
    end else if (idx == `IDX_BAND2) begin
      rv[`B_WIDTH] = cfg_q.band2_width_sel;
      if (wr_en) begin
        cfg_d.band2_width_sel = wd[`B_WIDTH];
      end
    end else if (idx == `IDX_BAND3) begin
      rv[`F_GAIN] = cfg_q.band3_gain;
      rv[`F_FREQ] = cfg_q.band3_centre_sel;
      rv[`B_WIDTH] = cfg_q.band3_width_sel;
      if (wr_en) begin
        cfg_d.band3_gain = wd[`F_GAIN];
        cfg_d.band3_centre_sel = wd[`F_FREQ];
        cfg_d.band3_width_sel = wd[`B_WIDTH];
      end
    end else if (idx == `IDX_BAND4) begin
      rv[`F_GAIN] = cfg_q.band4_gain;
      rv[`F_FREQ] = cfg_q.band4_centre_sel;
      rv[`B_WIDTH] = cfg_q.band4_width_sel;
      if (wr_en) begin
        cfg_d.band4_gain = wd[`F_GAIN];
        cfg_d.band4_centre_sel = wd[`F_FREQ];
        cfg_d.band4_width_sel = wd[`B_WIDTH];
      end
    end else if (idx == `IDX_BAND5) begin
      // shelving band has no width bit, bit 8 reads zero
      rv[`F_GAIN] = cfg_q.band5_gain;
      rv[`F_FREQ] = cfg_q.band5_cutoff_sel;
      if (wr_en) begin
        cfg_d.band5_gain = wd[`F_GAIN];
        cfg_d.band5_cutoff_sel = wd[`F_FREQ];
      end
    end else if (idx == `IDX_DEPTH) begin
      rv[`F_DEPTH] = cfg_q.stereo_depth;
      if (wr_en) begin
        cfg_d.stereo_depth = wd[`F_DEPTH];
      end
    end else if (idx == `IDX_XMIX) begin
      rv[`B_R2L] = cfg_q.right_play_to_left_mix;
      rv[`B_L2R] = cfg_q.left_play_to_right_mix;
      if (wr_en) begin
        cfg_d.right_play_to_left_mix = wd[`B_R2L];
        cfg_d.left_play_to_right_mix = wd[`B_L2R];
      end
    end else if (idx == `IDX_LMIX) begin
      rv[`B_SAME] = cfg_q.left_play_to_left_mix;
      rv[`B_BYP] = cfg_q.left_bypass_to_mix;
      rv[`F_BYP_LVL] = cfg_q.left_bypass_level;
      rv[`B_AUX] = cfg_q.left_aux_to_mix;
      rv[`F_AUX_LVL] = cfg_q.left_aux_level;
      if (wr_en) begin
        cfg_d.left_play_to_left_mix = wd[`B_SAME];
        cfg_d.left_bypass_to_mix = wd[`B_BYP];
        cfg_d.left_bypass_level = wd[`F_BYP_LVL];
        cfg_d.left_aux_to_mix = wd[`B_AUX];
        cfg_d.left_aux_level = wd[`F_AUX_LVL];
      end
    end else if (idx == `IDX_RMIX) begin
      // right mixer has no bypass select, bit 1 reads zero
      rv[`B_SAME] = cfg_q.right_play_to_right_mix;
      rv[`F_BYP_LVL] = cfg_q.right_bypass_level;
      rv[`B_AUX] = cfg_q.right_aux_to_mix;
      rv[`F_AUX_LVL] = cfg_q.right_aux_level;
      if (wr_en) begin
        cfg_d.right_play_to_right_mix = wd[`B_SAME];
        cfg_d.right_bypass_level = wd[`F_BYP_LVL];
        cfg_d.right_aux_to_mix = wd[`B_AUX];
        cfg_d.right_aux_level = wd[`F_AUX_LVL];
      end
    end else if (idx == `IDX_HP_L) begin
      // staging value reads back, commit bit is never stored
      rv[`F_LEVEL] = hp_l_stage_q;
      rv[`B_SILENCE] = cfg_q.left_phones_silence;
      rv[`B_ZC] = cfg_q.left_phones_zero_cross;
      if (wr_en) begin
        hp_l_stage_d = wd[`F_LEVEL];
        cfg_d.left_phones_silence = wd[`B_SILENCE];
        cfg_d.left_phones_zero_cross = wd[`B_ZC];
        commit_hp = wd[`B_COMMIT];
      end
    end else if (idx == `IDX_HP_R) begin
      rv[`F_LEVEL] = hp_r_stage_q;
      rv[`B_SILENCE] = cfg_q.right_phones_silence;
      rv[`B_ZC] = cfg_q.right_phones_zero_cross;
      if (wr_en) begin
        hp_r_stage_d = wd[`F_LEVEL];
        cfg_d.right_phones_silence = wd[`B_SILENCE];
        cfg_d.right_phones_zero_cross = wd[`B_ZC];
        commit_hp = wd[`B_COMMIT];
      end
    end else if (idx == `IDX_SPK_L) begin
      rv[`F_LEVEL] = spk_stage_q;
      rv[`B_SILENCE] = cfg_q.left_speaker_silence;
      rv[`B_ZC] = cfg_q.left_speaker_zero_cross;
      if (wr_en) begin
        spk_stage_d = wd[`F_LEVEL];
        cfg_d.left_speaker_silence = wd[`B_SILENCE];
        cfg_d.left_speaker_zero_cross = wd[`B_ZC];
        load_spk = 1'b1;
      end
    end else if (idx == `IDX_STATUS) begin
      rv[`B_ST_HP_L] = hp_l_pending;
      rv[`B_ST_HP_R] = hp_r_pending;
      rv[`B_ST_SPK] = spk_pending;
    end else begin
      hit = 1'b0;
    end
    // answer one cycle into the access phase, reads captured with it
    pready_d = access_start;
    pslverr_d = access_start && !hit;
    prdata_d = prdata_q;
    if (access_start) begin
      prdata_d = (hit && !pwrite) ? {{(`DATA_W-`REG_W){1'b0}}, rv} : '0;
    end
  end

  // register file flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= '0;
      cfg_q.shaping_path_sel <= `RST_PATH;
      cfg_q.band3_gain <= `RST_GAIN;
      cfg_q.band4_gain <= `RST_GAIN;
      cfg_q.band5_gain <= `RST_GAIN;
      cfg_q.band3_centre_sel <= `RST_FREQ;
      cfg_q.band4_centre_sel <= `RST_FREQ;
      cfg_q.band5_cutoff_sel <= `RST_FREQ;
      cfg_q.stereo_depth <= `RST_DEPTH;
      cfg_q.left_play_to_left_mix <= `RST_SAME;
      cfg_q.right_play_to_right_mix <= `RST_SAME;
      cfg_q.left_bypass_level <= `RST_MIX_LVL;
      cfg_q.left_aux_level <= `RST_MIX_LVL;
      cfg_q.right_bypass_level <= `RST_MIX_LVL;
      cfg_q.right_aux_level <= `RST_MIX_LVL;
      hp_l_stage_q <= `RST_LEVEL;
      hp_r_stage_q <= `RST_LEVEL;
      spk_stage_q <= `RST_LEVEL;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      cfg_q <= cfg_d;
      hp_l_stage_q <= hp_l_stage_d;
      hp_r_stage_q <= hp_r_stage_d;
      spk_stage_q <= spk_stage_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // zero-crossing inputs

  // two-stage synchroniser, then a rising-edge detect on the clean copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zc_meta_q <= '0;
      zc_sync_q <= '0;
      zc_last_q <= '0;
    end else begin
      zc_meta_q <= {spk_left_crossing, hp_right_crossing, hp_left_crossing};
      zc_sync_q <= zc_meta_q;
      zc_last_q <= zc_sync_q;
    end
  end

  assign zc_event = zc_sync_q & ~zc_last_q;

  //////////////////////////////////////////////////////////////////////
  // applied gains

  // one commit loads both phones channels in the same cycle
  gain_apply #(.WIDTH(6), .RESET_LEVEL(`RST_LEVEL)) hp_left_gain (
    .pclk(pclk),
    .presetn(presetn),
    .load(commit_hp),
    .target(hp_l_stage_d),
    .zc_en(cfg_d.left_phones_zero_cross),
    .zc_event(zc_event[0]),
    .level_q(hp_l_level),
    .pending_q(hp_l_pending)
  );

  gain_apply #(.WIDTH(6), .RESET_LEVEL(`RST_LEVEL)) hp_right_gain (
    .pclk(pclk),
    .presetn(presetn),
    .load(commit_hp),
    .target(hp_r_stage_d),
    .zc_en(cfg_d.right_phones_zero_cross),
    .zc_event(zc_event[1]),
    .level_q(hp_r_level),
    .pending_q(hp_r_pending)
  );

  // the speaker level has no commit of its own here and loads on write
  gain_apply #(.WIDTH(6), .RESET_LEVEL(`RST_LEVEL)) spk_left_gain (
    .pclk(pclk),
    .presetn(presetn),
    .load(load_spk),
    .target(spk_stage_d),
    .zc_en(cfg_d.left_speaker_zero_cross),
    .zc_event(zc_event[2]),
    .level_q(spk_level),
    .pending_q(spk_pending)
  );

  //////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign cfg = cfg_q;
  assign levels.left_phones_level = hp_l_level;
  assign levels.right_phones_level = hp_r_level;
  assign levels.left_speaker_level = spk_level;

endmodule

// [test/eq_mix_asserts.sv]
// concurrent checks on the ports of the shaping and output mix register bank
`include "eq_mix_defs.svh"

module eq_mix_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [`DATA_W-1:0] pwdata,
  input wire logic [`DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // zero-crossing indications
  input wire logic hp_left_crossing,
  input wire logic hp_right_crossing,
  input wire logic spk_left_crossing,
  // settings to the signal path
  input wire eq_mix_pkg::cfg_s cfg,
  input wire eq_mix_pkg::level_s levels
);

  logic acc;
  logic wr_done;
  logic hp_plain;
  logic spk_direct;
  logic [5:0] spk_w_d;
  logic [5:0] spk_w_q;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////////
  // decoded bus events
  assign acc = psel && penable && !pready;
  assign wr_done = psel && penable && pready && pwrite;
  assign hp_plain = wr_done && paddr == {`IDX_HP_L, 2'b00} && !pwdata[`B_COMMIT]
    && !pwdata[`B_ZC] && !cfg.left_phones_zero_cross && !cfg.right_phones_zero_cross;
  assign spk_direct = wr_done && paddr == {`IDX_SPK_L, 2'b00} && !pwdata[`B_ZC];

  // last speaker level written with zero-cross off
  always_comb begin
    spk_w_d = spk_w_q;
    if (spk_direct) begin
      spk_w_d = pwdata[5:0];
    end
  end

  // register the expected speaker level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spk_w_q <= `RST_LEVEL;
    end else begin
      spk_w_q <= spk_w_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus timing
  chk_ready_one_wait: assert property (acc |=> pready)
    else $error("pready did not follow the access phase");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_err_misaligned: assert property (acc && paddr[1:0] != 2'b00 |=> pready && pslverr)
    else $error("misaligned access not refused");
  chk_err_data_zero: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
    else $error("refused access returned data");
  chk_rdata_upper: assert property (pready |-> prdata[31:9] == 23'h00_0000)
    else $error("read data above bit 8 not zero");

  // register behaviour
  chk_path_locked: assert property (cfg.left_record_conv_en || cfg.right_record_conv_en
    || cfg.left_playback_conv_en || cfg.right_playback_conv_en
    |=> $stable(cfg.shaping_path_sel))
    else $error("path select changed with a converter enabled");
  chk_phones_staged: assert property (hp_plain |=>
    ($stable(levels.left_phones_level) && $stable(levels.right_phones_level))[*3])
    else $error("phones level applied without commit");
  chk_spk_direct: assert property (spk_direct |-> ##[1:2]
    (levels.left_speaker_level == spk_w_q))
    else $error("speaker level not applied at once");
  // a write that clears zero-cross applies its level at once, so it is left out here
  chk_spk_zc_wait: assert property ((cfg.left_speaker_zero_cross && !spk_left_crossing)[*6]
    ##0 !spk_direct |=> $stable(levels.left_speaker_level))
    else $error("speaker level changed without a crossing");

endmodule

bind eq_3d_output_mix_ctrl_regs eq_mix_asserts chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .hp_left_crossing(hp_left_crossing), .hp_right_crossing(hp_right_crossing),
  .spk_left_crossing(spk_left_crossing), .cfg(cfg), .levels(levels)
);

// [test/test_eq_3d_output_mix_ctrl_regs.sv]
// self-checking bench for the shaping and output mix register bank
`include "eq_mix_defs.svh"

module test_eq_3d_output_mix_ctrl_regs;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`ADDR_W-1:0] paddr = '0;
  logic [`DATA_W-1:0] pwdata = '0;
  logic [`DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic hp_left_crossing = 1'b0;
  logic hp_right_crossing = 1'b0;
  logic spk_left_crossing = 1'b0;
  eq_mix_pkg::cfg_s cfg;
  eq_mix_pkg::level_s levels;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] rd_q;
  logic err_q;
  logic [7:0] ridx_t [14] = '{`IDX_POWER, `IDX_PATH, `IDX_BAND2, `IDX_BAND3, `IDX_BAND4,
    `IDX_BAND5, `IDX_DEPTH, `IDX_XMIX, `IDX_LMIX, `IDX_RMIX, `IDX_HP_L, `IDX_HP_R,
    `IDX_SPK_L, `IDX_REC_EN};
  logic [8:0] rst_t [14] = '{9'h000, 9'h100, 9'h000, 9'h02c, 9'h02c, 9'h02c, 9'h000,
    9'h000, 9'h001, 9'h001, 9'h039, 9'h039, 9'h039, 9'h000};
  logic [7:0] pidx_t [10] = '{`IDX_POWER, `IDX_BAND2, `IDX_BAND3, `IDX_BAND4, `IDX_BAND5,
    `IDX_DEPTH, `IDX_XMIX, `IDX_LMIX, `IDX_RMIX, `IDX_REC_EN};
  logic [8:0] mask_t [10] = '{9'h00f, 9'h100, 9'h17f, 9'h17f, 9'h07f, 9'h00f, 9'h060,
    9'h1ff, 9'h1fd, 9'h003};
  logic [8:0] pat_t [4] = '{9'h1ff, 9'h155, 9'h0aa, 9'h000};

  // device under test
  eq_3d_output_mix_ctrl_regs uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hp_left_crossing(hp_left_crossing), .hp_right_crossing(hp_right_crossing),
    .spk_left_crossing(spk_left_crossing), .cfg(cfg), .levels(levels)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #5 pclk = ~pclk;

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare, bus and closing tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one apb transfer; pready is read before this edge's updates land
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [1:0] lo,
                      input logic [8:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, lo};
    pwdata <= {23'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // wait as long as the slave needs, only the hang guard ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [8:0] exp, input string name);
    xfer(1'b0, idx, 2'b00, 9'h000);
    check(name, rd_q, {23'h00_0000, exp});
    check({name, " slverr"}, {31'h0000_0000, err_q}, 32'h0000_0000);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [8:0] d);
    xfer(1'b1, idx, 2'b00, d);
    check("write slverr", {31'h0000_0000, err_q}, 32'h0000_0000);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic results();
    if (num_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence: reset values, readback, path lock, refused accesses, phones and speaker levels
  initial begin
    int i;
    int p;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("reset levels", {14'h0000, levels}, {14'h0000, {3{6'h39}}});
    check("reset path", {31'h0000_0000, cfg.shaping_path_sel}, 32'h0000_0001);
    for (i = 0; i < 14; i++) begin
      rd(ridx_t[i], rst_t[i], "reset");
    end
    // every pattern through every plain register, all codes of the 2-bit fields included
    for (p = 0; p < 4; p++) begin
      for (i = 0; i < 10; i++) wr(pidx_t[i], pat_t[p]);
      for (i = 0; i < 10; i++) begin
        rd(pidx_t[i], pat_t[p] & mask_t[i], "readback");
      end
      check("cutoff", {30'h0, cfg.band5_cutoff_sel}, {30'h0, pat_t[p][6:5]});
      check("depth", {28'h0, cfg.stereo_depth}, {28'h0, pat_t[p][3:0]});
      check("aux level", {29'h0, cfg.left_aux_level}, {29'h0, pat_t[p][8:6]});
      check("mix on", {30'h0, cfg.left_mixer_on, cfg.right_mixer_on},
            {30'h0, pat_t[p][2], pat_t[p][3]});
    end
    // path select refuses changes while any converter runs
    wr(`IDX_POWER, 9'h001);
    wr(`IDX_PATH, 9'h000);
    rd(`IDX_PATH, 9'h100, "path locked play");
    wr(`IDX_POWER, 9'h000);
    wr(`IDX_REC_EN, 9'h002);
    wr(`IDX_PATH, 9'h000);
    rd(`IDX_PATH, 9'h100, "path locked rec");
    wr(`IDX_REC_EN, 9'h000);
    wr(`IDX_PATH, 9'h000);
    rd(`IDX_PATH, 9'h000, "path record");
    check("path port", {31'h0000_0000, cfg.shaping_path_sel}, 32'h0000_0000);
    // refused accesses
    xfer(1'b0, 8'h20, 2'b00, 9'h000);
    check("unmapped slverr", {31'h0000_0000, err_q}, 32'h0000_0001);
    check("unmapped data", rd_q, 32'h0000_0000);
    xfer(1'b1, `IDX_DEPTH, 2'b10, 9'h005);
    check("misaligned slverr", {31'h0000_0000, err_q}, 32'h0000_0001);
    rd(`IDX_DEPTH, 9'h000, "misaligned dropped");
    // phones levels stay staged until the commit bit
    wr(`IDX_HP_L, 9'h00a);
    wait_n(4);
    check("phones held", {14'h0000, levels}, {14'h0000, {3{6'h39}}});
    rd(`IDX_HP_L, 9'h00a, "phones staged");
    wr(`IDX_HP_R, 9'h155);
    wait_n(2);
    check("phones commit", {20'h0_0000, levels[17:6]}, {20'h0_0000, 6'h0a, 6'h15});
    check("phones mute", {30'h0, cfg.right_phones_silence, cfg.left_phones_silence},
          32'h0000_0002);
    rd(`IDX_HP_R, 9'h055, "commit not stored");
    // zero-cross defers each phones side to its own crossing
    wr(`IDX_HP_L, 9'h0a0);
    wr(`IDX_HP_R, 9'h1a1);
    rd(`IDX_STATUS, 9'h003, "phones pending");
    wait_n(8);
    check("phones wait", {20'h0_0000, levels[17:6]}, {20'h0_0000, 6'h0a, 6'h15});
    hp_left_crossing <= 1'b1;
    wait_n(3);
    hp_left_crossing <= 1'b0;
    wait_n(6);
    check("left crossing", {20'h0_0000, levels[17:6]}, {20'h0_0000, 6'h20, 6'h15});
    hp_right_crossing <= 1'b1;
    wait_n(3);
    hp_right_crossing <= 1'b0;
    wait_n(6);
    check("right crossing", {20'h0_0000, levels[17:6]}, {20'h0_0000, 6'h20, 6'h21});
    // speaker level: direct, then held for a crossing, then muted
    wr(`IDX_SPK_L, 9'h000);
    wait_n(2);
    check("speaker direct", {26'h0, levels.left_speaker_level}, 32'h0000_0000);
    wr(`IDX_SPK_L, 9'h0bf);
    rd(`IDX_STATUS, 9'h004, "speaker pending");
    wait_n(8);
    check("speaker wait", {26'h0, levels.left_speaker_level}, 32'h0000_0000);
    spk_left_crossing <= 1'b1;
    wait_n(3);
    spk_left_crossing <= 1'b0;
    wait_n(6);
    check("speaker crossing", {26'h0, levels.left_speaker_level}, 32'h0000_003f);
    wr(`IDX_SPK_L, 9'h079);
    wait_n(2);
    check("speaker mute", {30'h0, cfg.left_speaker_silence, cfg.left_speaker_zero_cross},
          32'h0000_0002);
    rd(`IDX_SPK_L, 9'h079, "speaker readback");
    results();
  end

endmodule
